/* sim/ppst_periph.sv */
// Purpose: peripheral device on the far side of the port pins
// Assumes: no pulls; an undriven pin shows what the device puts on it
// Notes: the device levels come from the bench
`timescale 1ns/10ps
`default_nettype none
module ppst_periph (
    input wire logic [7:0] port_lines_o,
    input wire logic [7:0] port_lines_oe_o,
    input wire logic control_line_two_o,
    input wire logic control_line_two_oe_o,
    input wire logic [7:0] drive_value,
    input wire logic strobe_level,
    input wire logic two_level,
    output wire logic [7:0] port_lines_i,
    output wire logic strobe_line_one_i,
    output wire logic control_line_two_i
);
    // wire level: port drives its outputs, device drives the rest
    assign port_lines_i = (port_lines_oe_o & port_lines_o) | (~port_lines_oe_o & drive_value);
    assign strobe_line_one_i = strobe_level;
    // line two belongs to whoever has it enabled
    assign control_line_two_i = control_line_two_oe_o ? control_line_two_o : two_level;
endmodule // ppst_periph
`default_nettype wire

/* sim/ppst_port_props.sv */
// Purpose: port-level checks for the parallel port with composite status
// Assumes: bus held steady by the bench for several clocks per access
// Notes: "quiet" means no bus strobe and no device reset for five clocks
`timescale 1ns/10ps
`default_nettype none
module ppst_port_props #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ext_reset_b_i,
    input wire bus_enable_i,
    input wire chip_select_i,
    input wire read_not_write_i,
    input wire timer_set_i,
    input wire timer_init_i,
    input wire [7:0] timer_control_i,
    input wire [7:0] data_out_o,
    input wire data_oe_o,
    input wire irq_b_o,
    input wire [WIDTH-1:0] port_lines_o,
    input wire [WIDTH-1:0] port_lines_oe_o,
    input wire control_line_two_o,
    input wire control_line_two_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // no access and no device reset long enough for the syncs to settle
    sequence bus_quiet;
        (!bus_enable_i && ext_reset_b_i)[*5];
    endsequence
    a_reset_out_values: assert property ($rose(rst_b_i) |-> irq_b_o && port_lines_oe_o == 0
        && !control_line_two_oe_o) else $error("outputs not at reset values");
    a_timer_irq_low: assert property (timer_set_i && timer_control_i[6] |-> ##[1:3] !irq_b_o)
        else $error("enabled timer flag did not pull irq low");
    a_ext_reset_port: assert property ((!ext_reset_b_i)[*8] |-> port_lines_oe_o == 0
        && port_lines_o == 0) else $error("device reset left port driven");
    a_irq_holds_low: assert property ((!bus_enable_i && ext_reset_b_i && !timer_init_i
        && !timer_control_i[0] && $stable(timer_control_i))[*5] ##0 !irq_b_o
        |=> !irq_b_o || $changed(timer_control_i) || timer_init_i)
        else $error("irq released with no clearing cause");
    a_dir_oe_holds: assert property (bus_quiet |=> $stable(port_lines_oe_o))
        else $error("port drive enable moved without access");
    a_line_two_holds: assert property (bus_quiet |=> $stable(control_line_two_oe_o))
        else $error("line two enable moved without access");
    a_read_data_holds: assert property (bus_quiet |=> $stable(data_out_o))
        else $error("read data changed without access");
    a_drive_on_read: assert property ($rose(data_oe_o) |-> chip_select_i && read_not_write_i
        && bus_enable_i) else $error("data bus driven outside a read");
    c_irq_low: cover property (!irq_b_o);
    c_read: cover property ($rose(data_oe_o));
    c_line_two_low: cover property (control_line_two_oe_o && !control_line_two_o);
endmodule // ppst_port_props
bind ppst_port ppst_port_props #(.WIDTH(WIDTH)) props_u (.clk_i, .rst_b_i, .ext_reset_b_i,
    .bus_enable_i, .chip_select_i, .read_not_write_i, .timer_set_i, .timer_init_i,
    .timer_control_i, .data_out_o, .data_oe_o, .irq_b_o, .port_lines_o, .port_lines_oe_o,
    .control_line_two_o, .control_line_two_oe_o);
`default_nettype wire

/* sim/ppst_port_tb.sv */
// Purpose: directed bench for the parallel port with composite status
// Assumes: each access holds the bus six clocks high and six low
// Notes: expected values follow the register map and flag rules
`timescale 1ns/10ps
`default_nettype none
module ppst_port_tb;
    logic clk_i = 1'h0, rst_b_i = 1'h0, ext_reset_b_i = 1'h1, bus_enable_i = 1'h0;
    logic chip_select_i = 1'h0, read_not_write_i = 1'h1, timer_set_i = 1'h0, timer_init_i = 1'h0;
    logic strobe_level = 1'h1, two_level = 1'h1;
    logic [2:0] reg_select_i = 3'h0;
    logic [7:0] data_in_i = 8'h00, timer_control_i = 8'h00, drive_value = 8'h00;
    wire [7:0] data_out_o, port_lines_i, port_lines_o, port_lines_oe_o;
    wire data_oe_o, irq_b_o, strobe_line_one_i, control_line_two_i;
    wire control_line_two_o, control_line_two_oe_o;
    int n_mismatch = 0, compares = 0;
    always #2.5 clk_i = ~clk_i;
    ppst_port #(.WIDTH(8)) dut_u (.clk_i, .rst_b_i, .ext_reset_b_i, .bus_enable_i,
        .chip_select_i, .read_not_write_i, .reg_select_i, .data_in_i, .data_out_o, .data_oe_o,
        .irq_b_o, .timer_set_i, .timer_init_i, .timer_control_i, .port_lines_i, .port_lines_o,
        .port_lines_oe_o, .strobe_line_one_i, .control_line_two_i, .control_line_two_o,
        .control_line_two_oe_o);
    ppst_periph periph_u (.port_lines_o, .port_lines_oe_o, .control_line_two_o,
        .control_line_two_oe_o, .drive_value, .strobe_level, .two_level, .port_lines_i,
        .strobe_line_one_i, .control_line_two_i);
    // compare one value, count it, report a mismatch
    task chk(input string n, input logic [7:0] v, input logic [7:0] e);
        compares++;
        if (v !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one bus access, held steady around the enable pulse
    task acc(input logic r, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_i);
        read_not_write_i <= r;
        reg_select_i <= s;
        data_in_i <= d;
        chip_select_i <= 1'h1;
        tick(2);
        bus_enable_i <= 1'h1;
        tick(6);
        bus_enable_i <= 1'h0;
        tick(6);
        chip_select_i <= 1'h0;
    endtask
    task rd(input logic [2:0] s, input logic [7:0] e);
        acc(1'h1, s, 8'h00);
        chk("read data", data_out_o, e);
    endtask
    task pin(input string n, input logic v, input logic e);
        chk(n, {7'h00, v}, {7'h00, e});
    endtask
    task tpulse(input logic set);
        @(posedge clk_i);
        if (set) timer_set_i <= 1'h1;
        else timer_init_i <= 1'h1;
        @(posedge clk_i);
        timer_set_i <= 1'h0;
        timer_init_i <= 1'h0;
        tick(4);
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 5000 clocks
    initial begin
        tick(8000);
        n_mismatch++;
        finish_test;
    end
    initial begin
        tick(2);
        rst_b_i <= 1'h1;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h80);
        acc(1'h0, 3'h2, 8'h0F);
        rd(3'h2, 8'h00);
        rd(3'h5, 8'h00);
        $display("reset test done");
        acc(1'h0, 3'h1, 8'h00);
        acc(1'h0, 3'h2, 8'h0F);
        rd(3'h2, 8'h0F);
        chk("drive enable", port_lines_oe_o, 8'h0F);
        drive_value <= 8'hA5;
        acc(1'h0, 3'h3, 8'hFF);
        chk("pin drive", port_lines_o & port_lines_oe_o, 8'h0F);
        rd(3'h3, 8'hAF);
        $display("direction test done");
        acc(1'h0, 3'h1, 8'h04);
        drive_value <= 8'h30;
        strobe_level <= 1'h0;
        tick(6);
        drive_value <= 8'hC0;
        strobe_level <= 1'h1;
        tick(6);
        strobe_level <= 1'h0;
        tick(6);
        rd(3'h0, 8'h02);
        pin("irq masked", irq_b_o, 1'h1);
        rd(3'h3, 8'h3F);
        rd(3'h0, 8'h00);
        $display("latch test done");
        acc(1'h0, 3'h1, 8'h03);
        strobe_level <= 1'h1;
        tick(6);
        pin("irq", irq_b_o, 1'h0);
        rd(3'h0, 8'h82);
        acc(1'h0, 3'h1, 8'h02);
        pin("irq", irq_b_o, 1'h1);
        acc(1'h0, 3'h1, 8'h03);
        pin("irq", irq_b_o, 1'h0);
        acc(1'h0, 3'h3, 8'h00);
        pin("irq", irq_b_o, 1'h1);
        $display("strobe test done");
        acc(1'h0, 3'h1, 8'h38);
        pin("line two", control_line_two_o & control_line_two_oe_o, 1'h1);
        acc(1'h0, 3'h1, 8'h30);
        pin("line two", control_line_two_o, 1'h0);
        acc(1'h0, 3'h1, 8'h28);
        rd(3'h3, 8'hC0);
        pin("line two", control_line_two_o, 1'h1);
        rd(3'h0, 8'h00);
        pin("line two", control_line_two_o, 1'h0);
        rd(3'h0, 8'h00);
        pin("line two", control_line_two_o, 1'h1);
        acc(1'h0, 3'h1, 8'h20);
        rd(3'h0, 8'h00);
        pin("line two", control_line_two_o, 1'h0);
        strobe_level <= 1'h0;
        tick(6);
        pin("line two", control_line_two_o, 1'h1);
        rd(3'h0, 8'h02);
        rd(3'h3, 8'hC0);
        rd(3'h0, 8'h00);
        pin("line two", control_line_two_o, 1'h0);
        acc(1'h0, 3'h1, 8'h00);
        two_level <= 1'h0;
        tick(6);
        rd(3'h0, 8'h04);
        acc(1'h0, 3'h1, 8'h08);
        pin("irq", irq_b_o, 1'h0);
        rd(3'h3, 8'hC0);
        pin("irq", irq_b_o, 1'h1);
        $display("line two test done");
        timer_control_i <= 8'h40;
        tpulse(1'h1);
        pin("irq", irq_b_o, 1'h0);
        rd(3'h0, 8'h81);
        tpulse(1'h0);
        rd(3'h0, 8'h00);
        tpulse(1'h1);
        timer_control_i <= 8'h48;
        acc(1'h0, 3'h6, 8'h00);
        rd(3'h0, 8'h00);
        tpulse(1'h1);
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h81);
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h00);
        tpulse(1'h1);
        timer_control_i <= 8'h41;
        tick(6);
        timer_control_i <= 8'h00;
        rd(3'h0, 8'h00);
        $display("timer test done");
        acc(1'h0, 3'h1, 8'h80);
        chk("drive enable", port_lines_oe_o, 8'h00);
        rd(3'h2, 8'h00);
        acc(1'h0, 3'h1, 8'h84);
        rd(3'h1, 8'h84);
        acc(1'h0, 3'h1, 8'h04);
        tpulse(1'h1);
        ext_reset_b_i <= 1'h0;
        tick(10);
        ext_reset_b_i <= 1'h1;
        tick(6);
        rd(3'h1, 8'h84);
        rd(3'h0, 8'h00);
        $display("port reset test done");
        finish_test;
    end
endmodule // ppst_port_tb
`default_nettype wire

/* src/ppst_consts.vh */
// Purpose: constants for the parallel port with composite status
// Assumes: byte-wide register bus, three select lines
// Notes: definitions only
`ifndef PPST_CONSTS_VH
`define PPST_CONSTS_VH
// register select codes
`define PPST_SEL_STATUS 3'h0
`define PPST_SEL_CONTROL 3'h1
`define PPST_SEL_DIRECTION 3'h2
`define PPST_SEL_DATA 3'h3
`define PPST_SEL_STATUS_MIRROR 3'h4
`define PPST_SEL_TIMER_CONTROL 3'h5
`define PPST_SEL_TIMER_MSB 3'h6
`define PPST_SEL_TIMER_LSB 3'h7
// status bit positions
`define PPST_ST_TIMER 0
`define PPST_ST_STROBE_ONE 1
`define PPST_ST_STROBE_TWO 2
`define PPST_ST_SUMMARY 7
// port control bit positions
`define PPST_PC_STROBE_IRQ_EN 0
`define PPST_PC_STROBE_EDGE 1
`define PPST_PC_LATCH_EN 2
`define PPST_PC_LINE_TWO_LEVEL 3
`define PPST_PC_LINE_TWO_MODE 4
`define PPST_PC_LINE_TWO_DIR 5
`define PPST_PC_PORT_RESET 7
// timer control bit positions used here
`define PPST_TC_SOFT_RESET 0
`define PPST_TC_INTERVAL 3
`define PPST_TC_IRQ_EN 6
// reset values
`define PPST_CONTROL_RESET 8'h80
`define PPST_BYTE_ZERO 8'h00
`endif

/* src/ppst_port.v */
// Purpose: 8-bit parallel port with its composite status and irq logic
// Assumes: bus enable strobe, pins and control lines arrive asynchronously
// Notes: timer counting is outside; timer events enter as one-cycle pulses
// Notes: every bus input is seen about two clocks after its pin moves
// Notes: the bus master must hold enable high and low for three clocks or more
// Notes: write data must stand from before enable rises until enable falls
`timescale 1ns/10ps
`default_nettype none
`include "ppst_consts.vh"

module ppst_port #(
    parameter WIDTH = 8 // port width
) (
    input wire clk_i, // system clock
    input wire rst_b_i, // synchronous reset, active low
    input wire ext_reset_b_i, // device reset pin, active low
    // processor bus side
    input wire bus_enable_i, // bus enable strobe, async
    input wire chip_select_i, // device selected, async
    input wire read_not_write_i, // high for read, async
    input wire [2:0] reg_select_i, // reg_select_hi/mid/lo, async
    input wire [7:0] data_in_i, // write data from processor
    output reg [7:0] data_out_o, // read data to processor
    output reg data_oe_o, // data bus drive enable
    output reg irq_b_o, // interrupt request, active low
    // timer section side
    input wire timer_set_i, // timer time-out pulse
    input wire timer_init_i, // counter initialization pulse
    input wire [7:0] timer_control_i, // timer control register copy
    // peripheral side
    input wire [WIDTH-1:0] port_lines_i, // port pins, async
    output reg [WIDTH-1:0] port_lines_o, // port pin drive level
    output reg [WIDTH-1:0] port_lines_oe_o, // port pin drive enable
    input wire strobe_line_one_i, // first control line, async
    input wire control_line_two_i, // second control line, async
    output reg control_line_two_o, // second control line level
    output reg control_line_two_oe_o // second control line enable
);

    // synchroniser stages, first stage read only by second
    // bus control pins and port pins share one pair of stages
    // so that select, direction and pins line up in time
    reg [WIDTH+5:0] sync_a;
    reg [WIDTH+5:0] sync_b;
    reg en_q; // previous enable level
    reg s1_q; // previous strobe one level
    reg s2_q; // previous line two level
    reg [7:0] port_control; // control register
    reg [WIDTH-1:0] port_direction; // direction register
    reg [WIDTH-1:0] port_data; // output data bits
    reg [WIDTH-1:0] latch_data; // captured input bits
    reg latch_full; // capture held
    // individual interrupt flags
    reg timer_irq_flag;
    reg strobe_one_flag;
    reg strobe_two_flag;
    reg seen_timer; // status read saw timer flag
    reg seen_one; // status read saw strobe flag
    reg seen_two; // status read saw second flag
    reg hs_pending; // handshake awaits enable edge
    reg hs_low; // handshake low phase
    // write data synchroniser
    reg [7:0] din_a; // write data, first stage
    reg [7:0] din_b; // write data, second stage

    // synchronised views
    // only these names are read by the logic below
    // the raw pins never reach a decode directly
    wire en_s = sync_b[0];
    wire cs_s = sync_b[1];
    wire rnw_s = sync_b[2];
    wire [2:0] sel_s = sync_b[5:3];
    wire [WIDTH-1:0] pins_s = sync_b[WIDTH+5:6];
    reg s1_a, s1_b, s2_a, s2_b, xr_a, xr_b; // control line and device reset syncs

    // access strobes on rising enable edge
    // each strobe lasts exactly one clock per bus access
    // so a long enable pulse counts as one access only
    // codes five to seven belong to the timer section
    wire en_rise = en_s & ~en_q;
    wire acc = en_rise & cs_s;
    wire rd = acc & rnw_s;
    wire wr = acc & ~rnw_s;
    wire rd_status = rd & ((sel_s == `PPST_SEL_STATUS) |
        (sel_s == `PPST_SEL_STATUS_MIRROR));
    wire data_acc = acc & (sel_s == `PPST_SEL_DATA);
    wire wr_latch = wr & ((sel_s == `PPST_SEL_TIMER_MSB) |
        (sel_s == `PPST_SEL_TIMER_LSB));
    wire rd_counter = rd & ((sel_s == `PPST_SEL_TIMER_MSB) |
        (sel_s == `PPST_SEL_TIMER_LSB));
    wire port_reset = port_control[`PPST_PC_PORT_RESET];
    wire ext_reset = ~xr_b;
    // timer reset condition
    // soft reset bit or device reset pin, both levels
    // this also clears both port flags
    wire timer_reset = timer_control_i[`PPST_TC_SOFT_RESET] | ext_reset;

    // edge detection with selectable polarity
    // previous levels reset to the idle high level
    // so no false edge follows a reset
    // line two only detects edges while it is an input
    wire s1_edge = port_control[`PPST_PC_STROBE_EDGE] ? (s1_b & ~s1_q) : (~s1_b & s1_q);
    wire line_two_out = port_control[`PPST_PC_LINE_TWO_DIR];
    wire s2_edge = ~line_two_out & (port_control[`PPST_PC_LINE_TWO_MODE] ?
        (s2_b & ~s2_q) : (~s2_b & s2_q));

    // status byte, unused bits zero
    // summary is a pure level function of flags and enables
    // so raising an enable with its flag set shows at once
    // second flag only counts while line two is an input
    wire summary = (timer_irq_flag & timer_control_i[`PPST_TC_IRQ_EN]) |
        (strobe_one_flag & port_control[`PPST_PC_STROBE_IRQ_EN]) |
        (strobe_two_flag & ~line_two_out &
        port_control[`PPST_PC_LINE_TWO_LEVEL]);
    wire [7:0] status = {summary, 4'h0, strobe_two_flag,
        strobe_one_flag, timer_irq_flag};

    // live or latched input bits
    // output bits always read back the data register
    // the latch never touches them
    wire [WIDTH-1:0] in_bits = latch_full ? latch_data : pins_s;
    wire [WIDTH-1:0] data_view = (port_data & port_direction) |
        (in_bits & ~port_direction);

    // input synchronisers
    // two stages for every pin from outside this clock
    // control line stages reset high, the idle level
    // device reset stages reset high, meaning not in reset
    // enable history starts low so reset is not an access
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync_a <= {(WIDTH+6){1'b0}};
            sync_b <= {(WIDTH+6){1'b0}};
            {s1_a, s1_b, s2_a, s2_b} <= 4'hF;
            {xr_a, xr_b} <= 2'h3;
            din_a <= `PPST_BYTE_ZERO;
            din_b <= `PPST_BYTE_ZERO;
            en_q <= 1'b0;
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            sync_a <= {port_lines_i, reg_select_i, read_not_write_i,
                chip_select_i, bus_enable_i};
            sync_b <= sync_a;
            s1_a <= strobe_line_one_i;
            s1_b <= s1_a;
            s2_a <= control_line_two_i;
            s2_b <= s2_a;
            xr_a <= ext_reset_b_i;
            xr_b <= xr_a;
            din_a <= data_in_i;
            din_b <= din_a;
            en_q <= en_s;
            s1_q <= s1_b;
            s2_q <= s2_b;
        end
    end

    // control register, port reset bit set wins
    // bit six is not implemented and reads zero
    // a write of zero to the reset bit loses
    // while the device reset pin is still low
    // the device reset pin leaves the other bits alone
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_control <= `PPST_CONTROL_RESET;
        end else begin
            if (wr && sel_s == `PPST_SEL_CONTROL) begin
                port_control[6:0] <= {1'b0, din_b[5:0]};
                port_control[7] <= din_b[7] | ext_reset;
            end else if (ext_reset) begin
                port_control[7] <= 1'b1;
            end
        end
    end

    // direction and data registers
    // both held clear while the port reset bit is set
    // so direction writes in that state are dropped
    // data writes keep the bits of input lines
    // software must clear the reset bit first
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_direction <= {WIDTH{1'b0}};
            port_data <= {WIDTH{1'b0}};
        // port reset bit overrides any write
        end else if (port_reset) begin
            port_direction <= {WIDTH{1'b0}};
            port_data <= {WIDTH{1'b0}};
        end else begin
            if (wr && sel_s == `PPST_SEL_DIRECTION) begin
                port_direction <= din_b[WIDTH-1:0];
            end
            if (wr && sel_s == `PPST_SEL_DATA) begin
                port_data <= (din_b[WIDTH-1:0] & port_direction) |
                    (port_data & ~port_direction);
            end
        end
    end

    // input latch, independent of outputs and irq
    // capture happens once, on the first active strobe edge
    // later edges are ignored until a data read
    // a data read releases the latch for the next capture
    // turning the feature off empties the latch
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            latch_data <= {WIDTH{1'b0}};
            latch_full <= 1'b0;
        end else if (!port_control[`PPST_PC_LATCH_EN]) begin
            latch_full <= 1'b0;
        end else if (rd && sel_s == `PPST_SEL_DATA) begin
            latch_full <= 1'b0;
        end else if (s1_edge && !latch_full) begin
            latch_data <= pins_s;
            latch_full <= 1'b1;
        end
    end

    // individual flags, set wins over clear
    // a qualified clear needs a status read that saw the flag
    // this keeps a flag raised after that read from being lost
    // timer reset and port reset beat a strobe set
    // the timer set beats every timer clear
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            timer_irq_flag <= 1'b0;
            strobe_one_flag <= 1'b0;
            strobe_two_flag <= 1'b0;
            seen_timer <= 1'b0;
            seen_one <= 1'b0;
            seen_two <= 1'b0;
        end else begin
            // timer flag
            // clears: reset, initialization, latch write in interval
            // mode, counter read after a qualifying status read
            if (timer_set_i) begin
                timer_irq_flag <= 1'b1;
            end else if (timer_reset || timer_init_i) begin
                timer_irq_flag <= 1'b0;
            end else if (wr_latch && timer_control_i[`PPST_TC_INTERVAL]) begin
                timer_irq_flag <= 1'b0;
            end else if (rd_counter && seen_timer) begin
                timer_irq_flag <= 1'b0;
            end
            // strobe one flag
            // set whatever its enable says
            // cleared by a data read or write once qualified
            if (port_reset || timer_reset) begin
                strobe_one_flag <= 1'b0;
            end else if (s1_edge) begin
                strobe_one_flag <= 1'b1;
            end else if (data_acc && seen_one) begin
                strobe_one_flag <= 1'b0;
            end
            // second flag
            // same clears as the strobe one flag
            // set only while line two is an input
            if (port_reset || timer_reset) begin
                strobe_two_flag <= 1'b0;
            end else if (s2_edge) begin
                strobe_two_flag <= 1'b1;
            end else if (data_acc && seen_two) begin
                strobe_two_flag <= 1'b0;
            end
            // qualification from last status read
            // each status read takes a fresh snapshot
            // a clearing access uses the snapshot up
            if (rd_status) begin
                seen_timer <= timer_irq_flag;
                seen_one <= strobe_one_flag;
                seen_two <= strobe_two_flag;
            end else begin
                if (rd_counter) begin
                    seen_timer <= 1'b0;
                end
                if (data_acc) begin
                    seen_one <= 1'b0;
                    seen_two <= 1'b0;
                end
            end
        end
    end

    // second control line output modes
    // mode bit set: plain output of the level bit
    // mode clear, level set: handshake pulse after data access
    // mode and level clear: acknowledge follows the strobe flag
    // line drives only when its direction bit is set
    // reset leaves it undriven at the idle high level
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            hs_pending <= 1'b0;
            hs_low <= 1'b0;
            control_line_two_o <= 1'b1;
            control_line_two_oe_o <= 1'b0;
        end else begin
            control_line_two_oe_o <= line_two_out;
            // handshake phase steps on each enable edge
            if (en_rise) begin
                hs_low <= hs_pending;
                hs_pending <= data_acc;
            end
            // plain output, handshake, then acknowledge
            if (port_control[`PPST_PC_LINE_TWO_MODE]) begin
                control_line_two_o <= port_control[`PPST_PC_LINE_TWO_LEVEL];
            end else if (port_control[`PPST_PC_LINE_TWO_LEVEL]) begin
                control_line_two_o <= ~(en_rise ? hs_pending : hs_low);
            end else if (s1_edge) begin
                control_line_two_o <= 1'b1;
            end else if (en_rise && !strobe_one_flag) begin
                control_line_two_o <= 1'b0;
            end
        end
    end

    // pins, read data and interrupt output
    // every output here is a flip-flop
    // read data follows the access by one clock
    // data bus drive follows the synchronised bus pins
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_lines_o <= {WIDTH{1'b0}};
            port_lines_oe_o <= {WIDTH{1'b0}};
            data_out_o <= `PPST_BYTE_ZERO;
            data_oe_o <= 1'b0;
            irq_b_o <= 1'b1;
        end else begin
            // pins show the registers one clock later
            port_lines_o <= port_data;
            port_lines_oe_o <= port_direction;
            irq_b_o <= ~summary;
            data_oe_o <= cs_s & rnw_s & en_s;
            // read data is loaded once per read and then held
            if (rd) begin
                case (sel_s)
                    `PPST_SEL_STATUS: data_out_o <= status;
                    `PPST_SEL_STATUS_MIRROR: data_out_o <= status;
                    `PPST_SEL_CONTROL: data_out_o <= port_control;
                    `PPST_SEL_DIRECTION: data_out_o <= port_direction;
                    `PPST_SEL_DATA: data_out_o <= data_view;
                    default: data_out_o <= `PPST_BYTE_ZERO; // timer regs elsewhere
                endcase
            end
        end
    end

endmodule // ppst_port
`default_nettype wire
